//--- rtl/acfpc_pkg.sv
// Shared constants and state types for the channel filter and phase block.
// Assumes one clock domain and a plain register port with one-cycle read latency.
package acfpc_pkg;
  localparam int NCH = 3;
  localparam int ACC_W = 32;
  localparam int DATA_W = 24;
  localparam int PH_W = 10;
  localparam int HPY_W = 48;
  localparam int FRAC_W = 16;
  localparam int ADDR_W = 8;
  // Register byte addresses
  localparam logic [7:0] ADDR_GLOBAL = 8'h00;
  localparam logic [7:0] ADDR_CHCFG0 = 8'h04;
  localparam logic [7:0] ADDR_DATA0 = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h1C;
  // Field positions
  localparam int OSR_LSB = 0;
  localparam int HP_LSB = 4;
  localparam int SEL_LSB = 0;
  localparam int BYP_BIT = 2;
  localparam int PH_LSB = 16;
  // Ratio codes: 0..4 give 64..1024, 5 and above give 4096
  localparam logic [2:0] OSR_CODE_4096 = 3'h5;
  localparam logic [3:0] OSR_LOG2_MIN = 4'h6;
  localparam logic [3:0] OSR_LOG2_S3MAX = 4'hA;
  localparam logic [2:0] RST_OSR = 3'h4;
  localparam logic [3:0] RST_HP = 4'h0;
  localparam logic [1:0] SINC1_LAST = 2'h3;
  localparam int DATA_SHIFT = 7;
  localparam int SINC1_SHIFT = 2;
  // Input select codes; 3 behaves as normal
  localparam logic [1:0] SEL_NORMAL = 2'h0;
  localparam logic [1:0] SEL_TEST_POS = 2'h1;
  localparam logic [1:0] SEL_TEST_NEG = 2'h2;

  typedef struct packed {
    logic [1:0] sel;
    logic hp_byp;
    logic [PH_W-1:0] phase;
    logic [ACC_W-1:0] i1;
    logic [ACC_W-1:0] i2;
    logic [ACC_W-1:0] i3;
    logic [ACC_W-1:0] d1;
    logic [ACC_W-1:0] d2;
    logic [ACC_W-1:0] d3;
    logic [ACC_W+1:0] acc4;
    logic [1:0] grp;
    logic [DATA_W-1:0] hp_x1;
    logic [HPY_W-1:0] hp_y;
    logic [DATA_W-1:0] data;
    logic valid;
    logic fresh;
  } acfpc_chan_t;

  typedef struct packed {
    logic [2:0] osr_sel;
    logic [3:0] hp_sel;
    logic [PH_W-1:0] mod_cnt;
    logic [31:0] rdata;
    logic ready_n;
    acfpc_chan_t [NCH-1:0] ch;
  } acfpc_state_t;

  // Clamp a wide signed value into the output word
  function automatic logic [DATA_W-1:0] acfpc_sat(input logic signed [HPY_W-1:0] v);
    logic signed [HPY_W-1:0] hi;
    logic signed [HPY_W-1:0] lo;
    hi = HPY_W'((64'sd1 <<< (DATA_W - 1)) - 64'sd1);
    lo = -hi - HPY_W'(1);
    if (v > hi)
      return {1'b0, {(DATA_W-1){1'b1}}};
    else if (v < lo)
      return {1'b1, {(DATA_W-1){1'b0}}};
    else
      return v[DATA_W-1:0];
  endfunction
endpackage

//--- rtl/acfpc_filter.sv
// Per-channel sinc decimation, DC-block high-pass, test-signal select and phase offset.
// Assumes modulator bits arrive synchronous to ref_clk, qualified by a one-cycle strobe.
//
// Contract
// (RQ1) Ratios up to 1024 decimate with a third-order sinc filter of length N.
// (RQ2) Frequency response is the cubed sinc shape set by N and modulator rate.
// (RQ3) Ratio 4096 uses sinc3 at 1024 followed by a four-tap sinc1.
// (RQ4) High-pass runs for any nonzero cutoff code; zero bypasses all channels.
// (RQ5) A per-channel bypass bit skips the high-pass even with nonzero cutoff.
// (RQ6) Cutoff code k sets coefficient a to two to the minus (k+1).
// (RQ7) High-pass updates once per output sample.
// (RQ8) Two-bit select feeds normal input or shared positive or negative test signal.
// (RQ9) Ten-bit signed phase offsets the window in modulator cycles.
// (RQ10) Phase range is -N/2 to N/2-1, or -512 to 511 above 1024.
// (RQ11) Out-of-range phase saturates to the nearest limit, never wraps.
// (RQ12) Each output word uses exactly N modulator samples.
// (RQ13) Equal phase settings give time-aligned windows on every channel.
// (RQ14) Phase settings move the moment result ready is asserted.
// (RQ15) Host handles whole-sample shifts below ratio 2048 by index offset.
// (RQ16) High-pass is first-order IIR, shift feedback, on 24-bit results.
// (RQ17) Select codes: 0 normal, 1 positive test, 2 negative test.
//
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module acfpc_filter (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Modulator streams
  input wire logic mod_strobe,
  input wire logic [acfpc_pkg::NCH-1:0] mod_bits,
  input wire logic test_bit,
  // Register port
  input wire logic [acfpc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Results
  output logic [acfpc_pkg::NCH*acfpc_pkg::DATA_W-1:0] chan_data,
  output logic [acfpc_pkg::NCH-1:0] chan_valid,
  output logic result_ready_n
);

  acfpc_pkg::acfpc_state_t state_reg;
  acfpc_pkg::acfpc_state_t state_next;
  acfpc_pkg::acfpc_chan_t chan_next [acfpc_pkg::NCH]; // Unpacked: one owner process per element
  logic [acfpc_pkg::NCH-1:0] fresh_all;
  logic [3:0] osr_log2;

  // Ratio as a power of two for the sinc3 stage; 4096 runs sinc3 at 1024
  assign osr_log2 = (state_reg.osr_sel >= acfpc_pkg::OSR_CODE_4096) ?
    acfpc_pkg::OSR_LOG2_S3MAX : acfpc_pkg::OSR_LOG2_MIN + {1'b0, state_reg.osr_sel};

  genvar gi;
  generate
    for (gi = 0; gi < acfpc_pkg::NCH; gi++)
    begin : g_chan
      logic signed [10:0] half;
      logic signed [10:0] ph_wide;
      logic signed [10:0] ph_eff;
      logic [10:0] mask;
      logic dump;
      logic in_bit;
      logic signed [acfpc_pkg::ACC_W-1:0] x;
      logic signed [acfpc_pkg::ACC_W-1:0] c1;
      logic signed [acfpc_pkg::ACC_W-1:0] c2;
      logic signed [acfpc_pkg::ACC_W-1:0] c3;
      logic signed [acfpc_pkg::ACC_W+1:0] norm;
      logic signed [acfpc_pkg::ACC_W+1:0] acc_sum;
      logic signed [acfpc_pkg::HPY_W-1:0] dec;
      logic signed [acfpc_pkg::HPY_W-1:0] xin;
      logic signed [acfpc_pkg::HPY_W-1:0] ynew;
      logic out_now;
      logic [4:0] k_shift;
      logic [7:0] cfg_addr;

      assign cfg_addr = acfpc_pkg::ADDR_CHCFG0 + 8'(4 * gi);

      // Per-channel next state; one instance of this logic per channel
      always_comb
      begin
        chan_next[gi] = state_reg.ch[gi];
        // (RQ10) limits follow the ratio
        half = 11'sd1 <<< (osr_log2 - 4'h1);
        ph_wide = {state_reg.ch[gi].phase[acfpc_pkg::PH_W-1], state_reg.ch[gi].phase};
        // (RQ11) clip, do not wrap
        if (ph_wide > half - 11'sd1)
          ph_eff = half - 11'sd1;
        else if (ph_wide < -half)
          ph_eff = -half;
        else
          ph_eff = ph_wide;
        // (RQ9) window start shifted by the phase in modulator cycles
        mask = (11'h001 << osr_log2) - 11'h001;
        // (RQ13) all channels count against one shared modulator counter
        dump = mod_strobe &&
          (((state_reg.mod_cnt ^ ph_eff[9:0]) & mask[9:0]) == 10'h000);
        // (RQ8) (RQ17) shared test source, inverted for the negative signal
        case (state_reg.ch[gi].sel)
          acfpc_pkg::SEL_TEST_POS: in_bit = test_bit;
          acfpc_pkg::SEL_TEST_NEG: in_bit = ~test_bit;
          default: in_bit = mod_bits[gi];
        endcase
        x = in_bit ? 32'sh00000001 : 32'shFFFFFFFF;
        c1 = '0;
        c2 = '0;
        c3 = '0;
        norm = '0;
        acc_sum = '0;
        dec = '0;
        xin = '0;
        ynew = '0;
        out_now = 1'b0;
        k_shift = 5'({1'b0, state_reg.hp_sel} + 5'h01);
        chan_next[gi].valid = 1'b0;
        // (RQ1) integrator chain at the modulator rate
        if (mod_strobe)
        begin
          chan_next[gi].i1 = state_reg.ch[gi].i1 + x;
          chan_next[gi].i2 = state_reg.ch[gi].i2 + chan_next[gi].i1;
          chan_next[gi].i3 = state_reg.ch[gi].i3 + chan_next[gi].i2;
        end
        // (RQ12) comb stage once per sinc3 window: N samples, or 1024 at ratio 4096
        if (dump)
        begin
          c1 = chan_next[gi].i3 - state_reg.ch[gi].d1;
          c2 = c1 - state_reg.ch[gi].d2;
          c3 = c2 - state_reg.ch[gi].d3;
          chan_next[gi].d1 = chan_next[gi].i3;
          chan_next[gi].d2 = c1;
          chan_next[gi].d3 = c2;
          // (RQ2) gain N cubed, scaled to the 1024 full scale
          norm = 34'(c3) <<< (5'h03 * (5'(acfpc_pkg::OSR_LOG2_S3MAX) - 5'(osr_log2)));
          if (state_reg.osr_sel >= acfpc_pkg::OSR_CODE_4096)
          begin
            // (RQ3) sinc1 sums four sinc3 results
            acc_sum = state_reg.ch[gi].acc4 + norm;
            chan_next[gi].grp = state_reg.ch[gi].grp + 2'h1;
            if (state_reg.ch[gi].grp == acfpc_pkg::SINC1_LAST)
            begin
              out_now = 1'b1;
              dec = 48'(acc_sum >>> (acfpc_pkg::DATA_SHIFT + acfpc_pkg::SINC1_SHIFT));
              chan_next[gi].acc4 = '0;
            end
            else
              chan_next[gi].acc4 = acc_sum;
          end
          else
          begin
            out_now = 1'b1;
            dec = 48'(norm >>> acfpc_pkg::DATA_SHIFT);
            chan_next[gi].acc4 = '0;
            chan_next[gi].grp = 2'h0;
          end
        end
        // (RQ7) high-pass steps only on a new output word
        if (out_now)
        begin
          xin = 48'(signed'(acfpc_pkg::acfpc_sat(dec)));
          // (RQ16) y = x - x1 + y1 - a*y1, y held with fraction bits
          ynew = ((xin - 48'(signed'(state_reg.ch[gi].hp_x1))) <<< acfpc_pkg::FRAC_W)
            + signed'(state_reg.ch[gi].hp_y)
            - (signed'(state_reg.ch[gi].hp_y) >>> k_shift);
          chan_next[gi].hp_x1 = xin[acfpc_pkg::DATA_W-1:0];
          chan_next[gi].hp_y = ynew;
          chan_next[gi].valid = 1'b1;
          // (RQ4) zero cutoff code and (RQ5) channel bypass skip the filter
          if (state_reg.hp_sel == 4'h0 || state_reg.ch[gi].hp_byp)
            chan_next[gi].data = xin[acfpc_pkg::DATA_W-1:0];
          else
            // (RQ6) a = 2^-(k+1) via the shift above
            chan_next[gi].data = acfpc_pkg::acfpc_sat(ynew >>> acfpc_pkg::FRAC_W);
        end
        // New word flag; a fresh word beats the collect that clears it
        if (fresh_all == '1)
          chan_next[gi].fresh = 1'b0;
        if (out_now)
          chan_next[gi].fresh = 1'b1;
        // Channel configuration writes
        if (reg_wr && reg_addr == cfg_addr)
        begin
          chan_next[gi].sel = reg_wdata[acfpc_pkg::SEL_LSB +: 2];
          chan_next[gi].hp_byp = reg_wdata[acfpc_pkg::BYP_BIT];
          chan_next[gi].phase = reg_wdata[acfpc_pkg::PH_LSB +: acfpc_pkg::PH_W];
        end
      end

      assign fresh_all[gi] = state_reg.ch[gi].fresh;
      assign chan_data[gi*acfpc_pkg::DATA_W +: acfpc_pkg::DATA_W] = state_reg.ch[gi].data;
      assign chan_valid[gi] = state_reg.ch[gi].valid;
    end
  endgenerate

  // Shared counter, global config, ready line and read mux
  always_comb
  begin
    state_next = state_reg;
    for (int i = 0; i < acfpc_pkg::NCH; i++)
    begin
      state_next.ch[i] = chan_next[i];
    end
    if (mod_strobe)
      state_next.mod_cnt = state_reg.mod_cnt + 10'h001;
    if (reg_wr && reg_addr == acfpc_pkg::ADDR_GLOBAL)
    begin
      state_next.osr_sel = reg_wdata[acfpc_pkg::OSR_LSB +: 3];
      state_next.hp_sel = reg_wdata[acfpc_pkg::HP_LSB +: 4];
    end
    state_next.rdata = 32'h00000000;
    if (reg_rd)
    begin
      if (reg_addr == acfpc_pkg::ADDR_GLOBAL)
        state_next.rdata = {24'h000000, state_reg.hp_sel, 1'b0, state_reg.osr_sel};
      else if (reg_addr == acfpc_pkg::ADDR_STATUS)
        state_next.rdata = {22'h000000, state_reg.mod_cnt};
      for (int i = 0; i < acfpc_pkg::NCH; i++)
      begin
        if (reg_addr == acfpc_pkg::ADDR_CHCFG0 + 8'(4 * i))
          state_next.rdata = {6'h00, state_reg.ch[i].phase, 13'h0000,
            state_reg.ch[i].hp_byp, state_reg.ch[i].sel};
        if (reg_addr == acfpc_pkg::ADDR_DATA0 + 8'(4 * i))
          state_next.rdata = {8'h00, state_reg.ch[i].data};
      end
      // A data read releases the ready line unless all channels are fresh in that cycle
      if (reg_addr >= acfpc_pkg::ADDR_DATA0 && reg_addr < acfpc_pkg::ADDR_STATUS)
        state_next.ready_n = 1'b1;
    end
    // (RQ14) ready follows the channel whose shifted window ends last
    if (fresh_all == '1)
      state_next.ready_n = 1'b0;
  end

  // State register with synchronous reset
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      state_reg <= '0;
      state_reg.osr_sel <= acfpc_pkg::RST_OSR;
      state_reg.hp_sel <= acfpc_pkg::RST_HP;
      state_reg.ready_n <= 1'b1;
    end
    else
      state_reg <= state_next;
  end

  assign reg_rdata = state_reg.rdata;
  assign result_ready_n = state_reg.ready_n;

endmodule // acfpc_filter

`default_nettype wire

//--- testbench/acfpc_filter_chk.sv
// Port checker for the channel filter block.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module acfpc_filter_chk (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Results
  input wire logic [71:0] chan_data,
  input wire logic [2:0] chan_valid,
  input wire logic result_ready_n
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  // A read taken at one address
  sequence s_rd(logic [7:0] a);
    reg_rd && reg_addr == a;
  endsequence
  // Read data only in the answer slot; reserved and unmapped space reads zero
  a_rdata_slot: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its slot");
  a_rd_unmapped: assert property (s_rd(8'h20) |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_global_resv: assert property (s_rd(8'h00) |=> reg_rdata[31:8] == 24'h0)
    else $error("global reserved bits set");
  a_cfg_resv: assert property (s_rd(8'h04) |=> reg_rdata[15:3] == 13'h0)
    else $error("config reserved bits set");
  // Words: one-cycle valid per channel, data moves only with valid
  a_valid_pulse: assert property (|chan_valid |=> !(chan_valid & $past(chan_valid)))
    else $error("valid longer than one cycle");
  a_data_hold: assert property (!chan_valid && $past(rst_b) |-> $stable(chan_data))
    else $error("data changed without valid");
  // Ready falls right after a word lands and rises only after a read
  a_ready_fall: assert property ($fell(result_ready_n) |-> |$past(chan_valid))
    else $error("ready without a new word");
  a_ready_rise: assert property ($rose(result_ready_n) && $past(rst_b) |-> $past(reg_rd))
    else $error("ready cleared without a read");
endmodule // acfpc_filter_chk
bind acfpc_filter acfpc_filter_chk u_acfpc_filter_chk (.ref_clk, .rst_b, .reg_addr, .reg_rd,
  .reg_rdata, .chan_data, .chan_valid, .result_ready_n);
`default_nettype wire

//--- testbench/acfpc_mod_src.sv
// Modulator stand-in: strobed bit streams for three channels and the shared test source.
// Assumes the bench sets pace and levels; idle cycles show inverted bits, never stale ones.
`timescale 1ns/1ps
`default_nettype none
module acfpc_mod_src (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Pace and levels
  input wire logic run,
  input wire logic slow,
  input wire logic [2:0] lvl,
  input wire logic tlvl,
  // Streams
  output logic mod_strobe,
  output logic [2:0] mod_bits,
  output logic test_bit
);
  logic ph_reg;
  // Slow pace strobes every other cycle to exercise a stalling modulator
  always_ff @(posedge ref_clk)
    ph_reg <= rst_b && !ph_reg;
  assign mod_strobe = run && (!slow || ph_reg);
  assign mod_bits = mod_strobe ? lvl : ~lvl;
  assign test_bit = mod_strobe ? tlvl : !tlvl;
endmodule // acfpc_mod_src
`default_nettype wire

//--- testbench/tb_acfpc_filter.sv
// Bench for the channel filter: registers, sinc words, select, high-pass, phase and ready.
// Assumes the modulator stand-in and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
module tb_acfpc_filter;
  logic ref_clk, rst_b, reg_wr, reg_rd, run, slow, tlvl, mod_strobe, test_bit, result_ready_n;
  logic [2:0] lvl, mod_bits, chan_valid, msk;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd_d, seed;
  logic [31:0] expv[3];
  logic [71:0] chan_data;
  int n_fail, num_checks, scnt, span, last[3], nw[3];
  acfpc_filter u_acfpc_filter (.ref_clk, .rst_b, .mod_strobe, .mod_bits, .test_bit, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .chan_data, .chan_valid, .result_ready_n);
  acfpc_mod_src u_acfpc_mod_src (.ref_clk, .rst_b, .run, .slow, .lvl, .tlvl, .mod_strobe,
    .mod_bits, .test_bit);
  // Clock
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Compare and count; automatic since the monitor and the main flow both call it
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want)
    begin
      n_fail++;
      $display("unexpected %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task wrap_up;
    if (n_fail == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Bus cycles; read data is taken just after the answer edge
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rd_d = reg_rdata;
  endtask
  // Stop streams, reprogram, restart; early words are transient and skipped
  task cfg(input logic [31:0] g, c0, c1, c2, input int sp);
    run <= 1'b0;
    wr(8'h00, g);
    wr(8'h04, c0);
    wr(8'h08, c1);
    wr(8'h0C, c2);
    nw = '{0, 0, 0};
    span = sp;
    run <= 1'b1;
  endtask
  // Model side: strobe count, window spacing and settled words per channel
  always @(posedge ref_clk)
  begin
    if (mod_strobe)
      scnt++;
    for (int i = 0; i < 3; i++)
      if (chan_valid[i])
      begin
        if (nw[i] > 1)
          chk(scnt - last[i], span);
        if (nw[i] > 3 && msk[i])
          chk(chan_data[i*24+:24], expv[i]);
        nw[i]++;
        last[i] = scnt;
      end
  end
  // Main sequence
  initial
  begin
    seed = 32'hEF25;
    {rst_b, reg_wr, reg_rd, run, slow, tlvl} = 6'h0;
    {reg_addr, reg_wdata, msk} = 43'h7;
    lvl = 3'h7;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    // Reset values, then an unmapped place that ignores a random write
    rd(8'h00);
    chk(rd_d, 32'h4);
    rd(8'h04);
    chk(rd_d, 32'h0);
    wr(8'h20, $random(seed));
    rd(8'h20);
    chk(rd_d, 32'h0);
    // select codes: test source held at -1, so negative test reads full scale
    expv = '{32'h7FFFFF, 32'h800000, 32'h7FFFFF};
    cfg(32'h0, 32'h0, 32'h1, 32'h2, 64);
    repeat (512) @(posedge ref_clk);
    run <= 1'b0;
    repeat (4) @(posedge ref_clk);
    #1 chk(result_ready_n, 1'b0);
    rd(8'h10);
    chk(rd_d[23:0], 32'h7FFFFF);
    chk(result_ready_n, 1'b1);
    // Other data slots and the shared strobe counter while the streams are stopped
    rd(8'h14);
    chk(rd_d, 32'h800000);
    rd(8'h18);
    chk(rd_d, 32'h7FFFFF);
    rd(8'h1C);
    chk(rd_d, 32'(scnt & 1023));
    // Slow strobes; phases 100 and -100 clip to 31 and -32 at ratio 64 instead of wrapping
    slow <= 1'b1;
    expv = '{3{32'h7FFFFF}};
    // Channel 0 uses the spare select code 3, which must route the normal input
    // whole-sample shifts stay with the host; phases 100 and -100 lie beyond the window to test clipping
    cfg(32'h0, 32'h3, 32'h0064_0000, 32'h039C_0000, 64);
    repeat (1024) @(posedge ref_clk);
    chk((last[1] - last[0]) & 63, 31);
    chk((last[2] - last[0]) & 63, 32);
    // Phase reads back as written; clipping is internal only
    rd(8'h08);
    chk(rd_d, 32'h0064_0000);
    rd(8'h04);
    chk(rd_d, 32'h3);
    // Cutoff code 1 with channel 0 bypassed: it holds full scale, the others decay to zero
    slow <= 1'b0;
    msk = 3'h1;
    cfg(32'h10, 32'h4, 32'h0, 32'h0, 64);
    repeat (5120) @(posedge ref_clk);
    #1 chk(chan_data[47:24] inside {24'h0, 24'hFFFFFF}, 1'b1);
    chk(chan_data[71:48] inside {24'h0, 24'hFFFFFF}, 1'b1);
    // Ratio code 2 is 256: plain sinc3, one word per 256 strobes
    msk = 3'h7;
    cfg(32'h2, 32'h0, 32'h0, 32'h0, 256);
    repeat (2048) @(posedge ref_clk);
    // code 7 means ratio 4096: one word per 4096 strobes
    cfg(32'h7, 32'h0, 32'h0, 32'h0, 4096);
    repeat (28672) @(posedge ref_clk);
    wrap_up;
  end
  // Watchdog sized above the roughly 37k cycles of traffic
  initial
  begin
    repeat (50000) @(posedge ref_clk);
    n_fail++;
    wrap_up;
  end
endmodule // tb_acfpc_filter
`default_nettype wire
